/* pkg/timer16_cc_regs.svh */
`ifndef TIMER16_CC_REGS_SVH
`define TIMER16_CC_REGS_SVH
// Register byte offsets
`define OFS_MODE_CTRL   8'h00
`define OFS_CC_CTRL     8'h04
`define OFS_PRESCALE    8'h08
`define OFS_COUNT       8'h0C
`define OFS_PRIMARY_CC  8'h10
`define OFS_SECOND_CC   8'h14
`define OFS_STATUS      8'h18
`define OFS_IRQ_MASK    8'h1C
// Field positions, mode control
`define MC_OVF_BIT      0
`define MC_OUTREV_BIT   1
`define MC_OPEN_LO      2
`define MC_OPEN_HI      3
// Field positions, capture/compare control
`define CC_PRI_CAP_BIT  0
`define CC_TRIG_SEL_BIT 1
`define CC_SEC_CAP_BIT  2
// Field positions, edge selection
`define PS_PRI_ES_LO    4
`define PS_PRI_ES_HI    5
`define PS_SEC_ES_LO    6
`define PS_SEC_ES_HI    7
// Field positions, pulse control
`define PC_SET_BIT      0
`define PC_BYTE_BIT     1
// Reset values and counter constants
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000
`define CNT_MAX         16'hFFFF
`define CNT_ONE         16'h0001
`endif

/* pkg/timer16_cc_pkg.sv */
package timer16_cc_pkg;
	// Operation-enable field codes
	typedef enum logic [1:0] {
		OP_STOP      = 2'h0,
		OP_FREE      = 2'h1,
		OP_CLR_PIN   = 2'h2,
		OP_CLR_MATCH = 2'h3
	} op_mode_e;
	// Edge-select codes
	typedef enum logic [1:0] {
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_NONE = 2'h2,
		EDGE_BOTH = 2'h3
	} edge_sel_e;
	// APB slave phase
	typedef enum logic [1:0] {
		APB_IDLE   = 2'h0,
		APB_ACCESS = 2'h1,
		APB_DONE   = 2'h3
	} apb_state_e;
endpackage : timer16_cc_pkg

/* design/timer16_capture_compare.sv */
// What this block does
// (R1) Software loads primary compare with 1..FFFF in interval/square/event modes.
// (R2) Secondary compare unused there; software masks secondary match interrupt.
// (R3) Free-run and clear-on-pin modes accept any 0..FFFF compare value.
// (R4) For pulse output software keeps secondary below primary.
// (R5) For one-shot software keeps the two compare values different.
// (R6) Compare value zero gives no match right after counting starts.
// (R7) Compare zero matches when count steps 0 to 1 after a clear.
// (R8) Primary captures on reverse primary phase or secondary edge per select bit.
// (R9) Primary edge code: 01 rise, 00 fall, 11 both; both gives no reverse capture.
// (R10) Secondary edge code: 01 rise, 00 fall, 11 both.
// (R11) Reverse-phase primary capture raises no primary interrupt.
// (R12) In reverse-phase mode a secondary edge only raises the primary interrupt.
// (R13) Primary capture on secondary edge always raises primary interrupt.
// (R14) Secondary captures on primary valid edge and raises secondary interrupt.
// (R15) Secondary capture ignores the primary trigger-select bit.
// (R16) Software rewrites mode control only to stop or clear overflow while running.
// (R17) Mode control takes bit or byte writes and resets to zero.
// (R18) Counting starts when enable is nonzero and stops when written 00.
// (R19) Enable: 00 stop/clear, 01 free, 10 clear on pin, 11 clear on match.
// (R20) Compare mode matches continuously; capture triggers ignored there.
// (R21) Overflow sets on FFFF to 0; clears by write zero or stop.
// (R22) Trigger pulses last two count clocks longer than the count period.
// (R23) Trigger pins synchronised before edge detection: one edge, one event.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "timer16_cc_regs.svh"
module timer16_capture_compare
	import timer16_cc_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	input  wire logic        i_count_en,
	input  wire logic        i_primary_trigger_pin,
	input  wire logic        i_secondary_trigger_pin,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_primary_irq,
	output logic             o_secondary_irq,
	output logic             o_overflow
);
	// Register state
	logic [7:0]  timer_mode_control_q;
	logic [7:0]  cc_control_q;
	logic [7:0]  prescaler_mode_q;
	logic [15:0] count_reg_q;
	logic [15:0] primary_cc_reg_q;
	logic [15:0] secondary_cc_reg_q;
	logic [15:0] count_reg_d;
	logic        started_q;
	logic [1:0]  pri_sync_q;
	logic [1:0]  sec_sync_q;
	logic        pri_prev_q;
	logic        sec_prev_q;
	apb_state_e  apb_q;

	// Decoded fields
	op_mode_e  op_mode;
	edge_sel_e pri_es;
	edge_sel_e sec_es;
	logic      running;
	logic      pri_capture_mode;
	logic      sec_capture_mode;
	logic      trig_reverse;
	assign op_mode = op_mode_e'({timer_mode_control_q[`MC_OPEN_HI],
		timer_mode_control_q[`MC_OPEN_LO]});
	assign pri_es = edge_sel_e'({prescaler_mode_q[`PS_PRI_ES_HI],
		prescaler_mode_q[`PS_PRI_ES_LO]});
	assign sec_es = edge_sel_e'({prescaler_mode_q[`PS_SEC_ES_HI],
		prescaler_mode_q[`PS_SEC_ES_LO]});
	assign running          = (op_mode != OP_STOP); // R18
	assign pri_capture_mode = cc_control_q[`CC_PRI_CAP_BIT];
	assign sec_capture_mode = cc_control_q[`CC_SEC_CAP_BIT];
	assign trig_reverse     = cc_control_q[`CC_TRIG_SEL_BIT];

	// Edge detection on the synchronised level only
	logic pri_lvl;
	logic sec_lvl;
	logic pri_rise;
	logic pri_fall;
	logic sec_rise;
	logic sec_fall;
	assign pri_lvl  = pri_sync_q[1];
	assign sec_lvl  = sec_sync_q[1];
	assign pri_rise = pri_lvl & ~pri_prev_q;
	assign pri_fall = ~pri_lvl & pri_prev_q;
	assign sec_rise = sec_lvl & ~sec_prev_q;
	assign sec_fall = ~sec_lvl & sec_prev_q;

	// Valid edges per selection
	logic pri_valid;
	logic pri_reverse;
	logic sec_valid;
	always_comb begin
		unique case (pri_es)
			EDGE_RISE: pri_valid = pri_rise;
			EDGE_FALL: pri_valid = pri_fall;
			EDGE_BOTH: pri_valid = pri_rise | pri_fall;
			default:   pri_valid = 1'b0;
		endcase
	end
	always_comb begin
		unique case (pri_es) // R9
			EDGE_RISE: pri_reverse = pri_fall;
			EDGE_FALL: pri_reverse = pri_rise;
			default:   pri_reverse = 1'b0; // Both edges: reverse phase undefined
		endcase
	end
	always_comb begin
		unique case (sec_es) // R10
			EDGE_RISE: sec_valid = sec_rise;
			EDGE_FALL: sec_valid = sec_fall;
			EDGE_BOTH: sec_valid = sec_rise | sec_fall;
			default:   sec_valid = 1'b0;
		endcase
	end

	// Count step and event terms
	logic tick;
	logic pri_match;
	logic sec_match;
	logic pri_cap;
	logic sec_cap;
	logic pri_ext_irq;
	logic clr_event;
	logic wrap;
	assign tick = running & i_count_en;
	// Zero compare: only the 0 to 1 step counts, and only after a clear or a wrap
	assign pri_match = tick & ~pri_capture_mode & started_q
		& (count_reg_q == primary_cc_reg_q); // R20
	assign sec_match = tick & ~sec_capture_mode & started_q
		& (count_reg_q == secondary_cc_reg_q); // R20
	assign pri_cap = running & pri_capture_mode
		& (trig_reverse ? pri_reverse : sec_valid); // R8
	assign sec_cap = running & sec_capture_mode & pri_valid; // R14 R15
	assign pri_ext_irq = running & pri_capture_mode & trig_reverse & sec_valid; // R12
	assign wrap = tick & (count_reg_q == `CNT_MAX);
	assign clr_event = ((op_mode == OP_CLR_PIN) & pri_valid)
		| ((op_mode == OP_CLR_MATCH) & pri_match);

	// APB decode
	logic       acc;
	logic       wr;
	logic       mapped;
	logic [7:0] wbyte;
	assign acc   = i_psel & i_penable & (apb_q == APB_ACCESS);
	assign wr    = i_psel & i_penable & i_pwrite & (apb_q == APB_DONE); // Lands with pready
	assign wbyte = i_pwdata[7:0];
	always_comb begin
		unique case (i_paddr)
			`OFS_MODE_CTRL, `OFS_CC_CTRL, `OFS_PRESCALE, `OFS_COUNT,
			`OFS_PRIMARY_CC, `OFS_SECOND_CC: mapped = 1'b1;
			default:                         mapped = 1'b0;
		endcase
	end

	// Counter next value
	always_comb begin
		count_reg_d = count_reg_q;
		if (!running) begin
			count_reg_d = `RST_WORD; // R19
		end else if (clr_event) begin
			count_reg_d = `RST_WORD; // R7
		end else if (tick) begin
			count_reg_d = count_reg_q + `CNT_ONE; // Wraps to zero
		end
	end

	// Counter register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			count_reg_q <= `RST_WORD;
		end else begin
			count_reg_q <= count_reg_d;
		end
	end

	// Match arms after first step or a clear; only the start step is skipped
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn || !running) begin
			started_q <= 1'b0; // R6
		end else if (tick || clr_event) begin
			started_q <= 1'b1; // R7
		end
	end

	// Trigger synchronisers and edge history
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			pri_sync_q <= 2'h0;
			sec_sync_q <= 2'h0;
			pri_prev_q <= 1'b0;
			sec_prev_q <= 1'b0;
		end else begin
			pri_sync_q <= {pri_sync_q[0], i_primary_trigger_pin}; // R23
			sec_sync_q <= {sec_sync_q[0], i_secondary_trigger_pin}; // R23
			pri_prev_q <= pri_lvl;
			sec_prev_q <= sec_lvl;
		end
	end

	// Mode control: byte write; bit 0 written zero clears overflow
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			timer_mode_control_q <= `RST_BYTE; // R17
		end else begin
			if (wr && i_paddr == `OFS_MODE_CTRL) begin
				timer_mode_control_q[`MC_OPEN_HI:`MC_OUTREV_BIT] <= wbyte[3:1]; // R17 R18
			end
			if (wrap) begin
				timer_mode_control_q[`MC_OVF_BIT] <= 1'b1; // R21 set wins
			end else if (!running) begin
				timer_mode_control_q[`MC_OVF_BIT] <= 1'b0; // R21
			end else if (wr && i_paddr == `OFS_MODE_CTRL) begin
				timer_mode_control_q[`MC_OVF_BIT] <= wbyte[`MC_OVF_BIT]; // R21
			end
		end
	end

	// Control registers written only while stopped
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			cc_control_q     <= `RST_BYTE;
			prescaler_mode_q <= `RST_BYTE;
		end else if (wr && !running) begin
			if (i_paddr == `OFS_CC_CTRL) begin
				cc_control_q <= {5'h00, wbyte[2:0]};
			end
			if (i_paddr == `OFS_PRESCALE) begin
				prescaler_mode_q <= {wbyte[7:4], 4'h0};
			end
		end
	end

	// Capture/compare registers; capture outranks a software write
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			primary_cc_reg_q   <= `RST_WORD;
			secondary_cc_reg_q <= `RST_WORD;
		end else begin
			if (pri_cap) begin
				primary_cc_reg_q <= count_reg_q; // R8
			end else if (wr && i_paddr == `OFS_PRIMARY_CC) begin
				primary_cc_reg_q <= i_pwdata[15:0];
			end
			if (sec_cap) begin
				secondary_cc_reg_q <= count_reg_q; // R14
			end else if (wr && i_paddr == `OFS_SECOND_CC) begin
				secondary_cc_reg_q <= i_pwdata[15:0];
			end
		end
	end

	// Interrupt pulses, one cycle each; overflow output is a registered copy of the flag level
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_primary_irq   <= 1'b0;
			o_secondary_irq <= 1'b0;
			o_overflow      <= 1'b0;
		end else begin
			// Reverse-phase capture deliberately silent
			o_primary_irq <= pri_match | (pri_cap & ~trig_reverse) | pri_ext_irq; // R11 R13
			o_secondary_irq <= sec_match | sec_cap; // R14
			o_overflow      <= timer_mode_control_q[`MC_OVF_BIT];
		end
	end

	// APB slave: one wait state, answer in the second access cycle
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			apb_q     <= APB_IDLE;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			unique case (apb_q)
				APB_IDLE: begin
					if (i_psel && !i_penable) begin
						apb_q <= APB_ACCESS;
					end
				end
				APB_ACCESS: begin
					if (acc) begin
						apb_q     <= APB_DONE;
						o_pready  <= 1'b1;
						o_pslverr <= ~mapped;
						unique case (i_paddr)
							`OFS_MODE_CTRL:  o_prdata <= {24'h0, timer_mode_control_q};
							`OFS_CC_CTRL:    o_prdata <= {24'h0, cc_control_q};
							`OFS_PRESCALE:   o_prdata <= {24'h0, prescaler_mode_q};
							`OFS_COUNT:      o_prdata <= {16'h0, count_reg_q};
							`OFS_PRIMARY_CC: o_prdata <= {16'h0, primary_cc_reg_q};
							`OFS_SECOND_CC:  o_prdata <= {16'h0, secondary_cc_reg_q};
							default:         o_prdata <= 32'h0000_0000;
						endcase
					end else begin
						apb_q <= APB_IDLE;
					end
				end
				APB_DONE: apb_q <= APB_IDLE;
				default:  apb_q <= APB_IDLE;
			endcase
		end
	end

	// Assertions
	property p_stop_clears; // R19
		@(posedge i_clk_sys) disable iff (!i_rstn)
		!running |=> count_reg_q == `RST_WORD;
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("count not cleared"); // R19

	property p_ovf_set; // R21
		@(posedge i_clk_sys) disable iff (!i_rstn)
		wrap |=> timer_mode_control_q[`MC_OVF_BIT] ##1 o_overflow;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow missed"); // R21

	property p_ovf_stop; // R21
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(!running && !wrap) |=> !timer_mode_control_q[`MC_OVF_BIT];
	endproperty
	a_ovf_stop: assert property (p_ovf_stop) else $error("overflow kept while stopped"); // R21

	property p_rev_silent; // R11
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(pri_cap && trig_reverse && !pri_match && !sec_valid) |=> !o_primary_irq;
	endproperty
	a_rev_silent: assert property (p_rev_silent) else $error("reverse capture irq"); // R11

	property p_pri_cap; // R8
		@(posedge i_clk_sys) disable iff (!i_rstn)
		pri_cap |=> primary_cc_reg_q == $past(count_reg_q);
	endproperty
	a_pri_cap: assert property (p_pri_cap) else $error("primary capture wrong"); // R8

	property p_sec_cap; // R14
		@(posedge i_clk_sys) disable iff (!i_rstn)
		sec_cap |=> o_secondary_irq && secondary_cc_reg_q == $past(count_reg_q);
	endproperty
	a_sec_cap: assert property (p_sec_cap) else $error("secondary capture wrong"); // R14

	property p_both_none; // R9
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(pri_es == EDGE_BOTH && trig_reverse) |-> !pri_cap;
	endproperty
	a_both_none: assert property (p_both_none) else $error("both-edge reverse captured"); // R9

	sequence s_zero_start;
		running && !started_q && tick;
	endsequence
	property p_zero_skip; // R6
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_zero_start |-> !pri_match && !sec_match;
	endproperty
	a_zero_skip: assert property (p_zero_skip) else $error("match at start"); // R6

	property p_ext_irq; // R12
		@(posedge i_clk_sys) disable iff (!i_rstn)
		pri_ext_irq |=> o_primary_irq && $stable(primary_cc_reg_q);
	endproperty
	a_ext_irq: assert property (p_ext_irq) else $error("external irq wrong"); // R12
endmodule : timer16_capture_compare

/* dv/trigger_source.sv */
`timescale 1ns/1ps
// External pulse source driving both trigger pins; pins idle low
module trigger_source #(
	parameter int HOLD = 6
) (
	input  wire logic i_clk,
	output logic      o_pri_pin,
	output logic      o_sec_pin
);
	initial begin
		o_pri_pin = 1'b0;
		o_sec_pin = 1'b0;
	end

	// High phase and low gap both outlast one count period plus two cycles
	task pulse(input logic sec);
		@(posedge i_clk);
		if (sec)
			o_sec_pin <= 1'b1;
		else
			o_pri_pin <= 1'b1;
		repeat (HOLD) @(posedge i_clk);
		o_sec_pin <= 1'b0;
		o_pri_pin <= 1'b0;
		repeat (HOLD) @(posedge i_clk);
	endtask : pulse
endmodule : trigger_source

/* dv/test_timer16_capture_compare.sv */
`timescale 1ns/1ps
`include "timer16_cc_regs.svh"
module test_timer16_capture_compare
	import timer16_cc_pkg::*;
;
	typedef struct packed {
		logic [2:0] cc;
		logic [7:0] ps;
		logic       pin;
		logic       pc;
		logic       sc;
		logic [1:0] pi;
		logic [1:0] si;
	} cap_case_s;
	// Control, edges, pin pulsed, captures and interrupt counts
	localparam cap_case_s CASES [10] = '{
		'{3'h5, 8'h50, 1'b1, 1'b1, 1'b0, 2'h1, 2'h0},
		'{3'h5, 8'h10, 1'b1, 1'b1, 1'b0, 2'h1, 2'h0},
		'{3'h5, 8'hD0, 1'b1, 1'b1, 1'b0, 2'h2, 2'h0},
		'{3'h5, 8'h50, 1'b0, 1'b0, 1'b1, 2'h0, 2'h1},
		'{3'h5, 8'h70, 1'b0, 1'b0, 1'b1, 2'h0, 2'h2},
		'{3'h7, 8'h50, 1'b0, 1'b1, 1'b1, 2'h0, 2'h1},
		'{3'h7, 8'h70, 1'b0, 1'b0, 1'b1, 2'h0, 2'h2},
		'{3'h7, 8'h50, 1'b1, 1'b0, 1'b0, 2'h1, 2'h0},
		'{3'h0, 8'h50, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0},
		'{3'h4, 8'h50, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0}
	};
	localparam logic [15:0] SENT = 16'h1234;

	logic        clk;
	logic        rstn;
	logic        count_en;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pri_irq;
	logic        sec_irq;
	logic        ovf;
	logic        pri_pin;
	logic        sec_pin;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	cap_case_s   c;
	logic [15:0] k;
	logic [31:0] r;
	int          p0;
	int          s0;
	int          n;
	int          n_pri = 0;
	int          n_sec = 0;
	int          err_count = 0;
	int          n_compared = 0;

	timer16_capture_compare i_dut (
		.i_clk_sys               (clk),
		.i_rstn                  (rstn),
		.i_count_en              (count_en),
		.i_primary_trigger_pin   (pri_pin),
		.i_secondary_trigger_pin (sec_pin),
		.i_psel                  (psel),
		.i_penable               (penable),
		.i_pwrite                (pwrite),
		.i_paddr                 (paddr),
		.i_pwdata                (pwdata),
		.o_prdata                (prdata),
		.o_pready                (pready),
		.o_pslverr               (pslverr),
		.o_primary_irq           (pri_irq),
		.o_secondary_irq         (sec_irq),
		.o_overflow              (ovf)
	);

	trigger_source i_src (
		.i_clk     (clk),
		.o_pri_pin (pri_pin),
		.o_sec_pin (sec_pin)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	task check(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	// Oldest note against each answer; write data is not compared
	always @(posedge clk) begin
		if (pready === 1'b1) begin
			e = exp_q.pop_front();
			check({pslverr, e[33] ? prdata : e[31:0]}, e[32:0]);
		end
	end

	// Interrupt pulse tallies
	always @(posedge clk) begin
		if (pri_irq === 1'b1)
			n_pri++;
		if (sec_irq === 1'b1)
			n_sec++;
	end

	// One transfer; note is {compare data, error, data}
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
		exp_q.push_back(x);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 34'h0);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] d);
		apb(1'b0, a, 32'h0, {2'b10, d});
	endtask : rd

	// Exactly m count steps
	task step(input int m);
		count_en <= 1'b1;
		repeat (m) @(posedge clk);
		count_en <= 1'b0;
	endtask : step

	// Watchdog sized for one counter wrap plus the short scenarios
	initial begin
		#2250000;
		err_count++;
		finish_test();
	end

	initial begin
		rstn = 1'b0;
		count_en = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		void'($urandom(35));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < 24; a += 4)
			rd(8'(a), 32'h0);
		apb(1'b0, 8'h40, 32'h0, {2'b11, 32'h0});
		apb(1'b1, 8'h40, $urandom, {2'b01, 32'h0});
		for (int a = 16; a < 24; a += 4) begin
			r = $urandom;
			wr(8'(a), r);
			rd(8'(a), {16'h0, r[15:0]});
		end
		// Counter frozen at k while each pin pulse arrives
		for (int i = 0; i < 10; i++) begin
			c = CASES[i];
			k = 16'($urandom_range(200, 1));
			wr(`OFS_MODE_CTRL, 32'h0);
			wr(`OFS_CC_CTRL, {29'h0, c.cc});
			wr(`OFS_PRESCALE, {24'h0, c.ps});
			wr(`OFS_PRIMARY_CC, {16'h0, SENT});
			wr(`OFS_SECOND_CC, {16'h0, SENT});
			wr(`OFS_MODE_CTRL, {28'h0, OP_FREE, 2'b00});
			wr(`OFS_CC_CTRL, 32'h0);
			step(k);
			rd(`OFS_COUNT, {16'h0, k});
			p0 = n_pri;
			s0 = n_sec;
			i_src.pulse(c.pin);
			rd(`OFS_PRIMARY_CC, {16'h0, c.pc ? k : SENT});
			rd(`OFS_SECOND_CC, {16'h0, c.sc ? k : SENT});
			rd(`OFS_CC_CTRL, {29'h0, c.cc});
			check(33'(n_pri - p0), 33'(c.pi));
			check(33'(n_sec - s0), 33'(c.si));
		end
		// Clear and start on primary rising edge
		wr(`OFS_MODE_CTRL, 32'h0);
		wr(`OFS_CC_CTRL, 32'h0);
		wr(`OFS_PRESCALE, 32'h10);
		wr(`OFS_MODE_CTRL, {28'h0, OP_CLR_PIN, 2'b00});
		step(k);
		i_src.pulse(1'b0);
		step(7);
		rd(`OFS_COUNT, 32'h7);
		// Clear and start on primary match, secondary at zero
		wr(`OFS_MODE_CTRL, 32'h0);
		wr(`OFS_PRIMARY_CC, 32'h9);
		wr(`OFS_SECOND_CC, 32'h0);
		wr(`OFS_MODE_CTRL, {28'h0, OP_CLR_MATCH, 2'b00});
		p0 = n_pri;
		s0 = n_sec;
		step(100);
		wr(`OFS_MODE_CTRL, 32'h0);
		check(33'((n_pri - p0) inside {[9:11]}), 33'h1);
		check(33'((n_pri - p0) - (n_sec - s0) inside {[0:1]}), 33'h1);
		check(33'(ovf), 33'h0);
		// Free run through one wrap, secondary at zero
		wr(`OFS_PRIMARY_CC, 32'h5);
		wr(`OFS_MODE_CTRL, {28'h0, OP_FREE, 2'b00});
		p0 = n_pri;
		s0 = n_sec;
		count_en <= 1'b1;
		repeat (50) @(posedge clk);
		check(33'(n_pri - p0), 33'h1);
		check(33'(n_sec - s0), 33'h0);
		n = 0;
		while (ovf !== 1'b1 && n < 70000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 70000)
			err_count++;
		repeat (20) @(posedge clk);
		count_en <= 1'b0;
		check(33'(n_pri - p0), 33'h2);
		check(33'(n_sec - s0), 33'h1);
		rd(`OFS_MODE_CTRL, 32'h5);
		wr(`OFS_MODE_CTRL, 32'h4);
		rd(`OFS_MODE_CTRL, 32'h4);
		check(33'(ovf), 33'h0);
		wr(`OFS_MODE_CTRL, 32'h0);
		rd(`OFS_COUNT, 32'h0);
		rd(`OFS_MODE_CTRL, 32'h0);
		repeat (4) @(posedge clk);
		finish_test();
	end
endmodule : test_timer16_capture_compare
